// >>> logic/swm_top.sv
// swm_top: warning detection, hold, masking and output routing with APB registers
// assumes causes and command conditions are synchronous to pclk
`timescale 1ns/10ps
module swm_top #(
  parameter int FAN_CYC = swm_pkg::FAN_CYC
) (
  // clock, reset, enable
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [17:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // causes
  input  wire swm_pkg::swm_cause_s cause,
  input  wire swm_pkg::swm_cmd_s   cmd,
  input  wire logic                error_reset,
  // warning lines and error
  output logic                     warning_out_a,
  output logic                     warning_out_b,
  output logic                     command_error
);
  typedef struct packed {
    swm_pkg::swm_bus_e          bus;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       err;
    logic [swm_pkg::NW-1:0]     act;
    logic [15:0]                enc_run;
    logic [15:0]                dset_run;
    logic                       cmd_err;
    logic                       out_a;
    logic                       out_b;
    logic                       rf_pend;  // register-file read in flight
    logic                       ctrl_rst; // software error reset pulse
    logic                       ctrl_clr;
  } swm_state_s;
  swm_state_s st_reg, st_next;

  // settings store
  logic             rf_we;
  logic [2:0]       rf_waddr;
  logic [2:0]       rf_raddr;
  logic [15:0]      rf_rdata;
  logic [7:0][15:0] words;
  logic             fan_exp;

  // decode an index to a storage slot; shared by read and write paths
  function automatic logic [3:0] dec(input logic [15:0] idx);
    if (idx == swm_pkg::IDX_OUT_SEL_A) begin
      dec = 4'h8;
    end else if (idx == swm_pkg::IDX_OUT_SEL_B) begin
      dec = 4'h9;
    end else if (idx == swm_pkg::IDX_GEN_MASK) begin
      dec = 4'hA;
    end else if (idx == swm_pkg::IDX_HOLD_SEL) begin
      dec = 4'hB;
    end else if (idx == swm_pkg::IDX_DSET_LIMIT) begin
      dec = 4'hC;
    end else if (idx == swm_pkg::IDX_LINK_MASK) begin
      dec = 4'hD;
    end else if (idx == swm_pkg::IDX_ENC_LIMIT) begin
      dec = 4'hE;
    end else if (idx == swm_pkg::IDX_STATUS) begin
      dec = 4'h1;
    end else if (idx == swm_pkg::IDX_CONTROL) begin
      dec = 4'h2;
    end else begin
      dec = 4'h0;
    end
  endfunction

  logic [15:0] idx;
  logic [3:0]  slot_dec;
  logic        wr_go;
  assign idx      = paddr[17:2];
  assign slot_dec = dec(idx);
  assign wr_go    = psel && penable && pwrite && st_reg.bus == swm_pkg::ST_SETUP;
  assign rf_we    = wr_go && slot_dec[3] && ce;
  assign rf_waddr = slot_dec[2:0];
  assign rf_raddr = slot_dec[2:0];

  swm_regfile u_rf (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .we      (rf_we),
    .waddr   (rf_waddr),
    .wdata   (pwdata[15:0]),
    .raddr   (rf_raddr),
    .rdata   (rf_rdata),
    .words   (words)
  );

  swm_fan_timer #(.FAN_CYC(FAN_CYC)) u_fan (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .stopped (cause.fan_stopped),
    .expired (fan_exp)
  );

  // settings words by name
  logic [15:0] sel_a, sel_b, gen_mask, hold_sel, dset_lim, link_mask, enc_lim;
  assign sel_a     = words[0];
  assign sel_b     = words[1];
  assign gen_mask  = words[2];
  assign hold_sel  = words[3];
  assign dset_lim  = words[4];
  assign link_mask = words[5];
  assign enc_lim   = words[6];

  // raw conditions per slot, slot 10 reserved and never raised
  logic [swm_pkg::NW-1:0] raw;
  logic                   cmd_warn;
  logic                   dset_bad;
  always_comb begin
    cmd_warn = cmd.cond_unmet
      || (cmd.brake_req && cmd.servo_on)
      || (cmd.switch_on_cmd && !cmd.main_power_on && cmd.obj_3508_zero)
      || (cmd.speed_mms >= swm_pkg::SPEED_LIMIT_MMS)
      || (cmd.enable_op_cmd && !cmd.mode_set)
      || (cmd.latch_start && (cmd.homing || cmd.data_clearing
          || cmd.config_busy || !cmd.remote))
      || (cmd.prohib_dir_cmd && cmd.prohib_stopped);
    dset_bad = cause.obj_write && cause.obj_out_range;
    raw      = '0;
    raw[0]   = cause.load_pct >= swm_pkg::LOAD_PCT_LIMIT;
    raw[1]   = cause.regen_pct >= swm_pkg::LOAD_PCT_LIMIT;
    raw[2]   = fan_exp;
    raw[3]   = cause.vibration;
    raw[4]   = cause.life_end;
    raw[5]   = cause.enc_warn;
    raw[6]   = st_reg.enc_run > enc_lim;
    raw[7]   = dset_bad;
    raw[8]   = cmd_warn;
    raw[9]   = cause.link_comm_err;
    raw[10]  = 1'b0;
  end

  // masking and hold per slot
  logic [swm_pkg::NW-1:0] det, latch_mode, act_next;
  logic                   clr_all;
  assign clr_all = error_reset || st_reg.ctrl_rst;
  genvar g;
  generate
    for (g = 0; g < swm_pkg::NW; g++) begin : g_slot
      localparam swm_pkg::swm_slot_s S = swm_pkg::slot(g);
      logic msk;
      assign msk = S.link ? link_mask[S.mbit] : gen_mask[S.mbit];
      assign det[g] = raw[g] && !msk;
      // life expectancy ignores hold selection
      assign latch_mode[g] = S.fixed_latch
        || hold_sel[swm_pkg::HOLD_GEN_BIT[3:0]];
      // detection wins over reset, so a persisting cause re-raises at once
      assign act_next[g] = det[g]
        || (latch_mode[g] && st_reg.act[g] && !clr_all);
    end
  endgenerate

  // route to a line: 0 takes any, else only the matching code
  function automatic logic route(input logic [15:0] sel,
                                 input logic [swm_pkg::NW-1:0] a);
    logic r;
    r = 1'b0;
    for (int i = 0; i < swm_pkg::NW; i++) begin
      if (a[i] && (sel == 16'h0000 || sel == {12'h000, swm_pkg::slot(i).sel})) begin
        r = 1'b1;
      end
    end
    route = r;
  endfunction

  // bus, counters and outputs
  always_comb begin
    st_next          = st_reg;
    st_next.ctrl_rst = 1'b0;
    st_next.ctrl_clr = 1'b0;
    st_next.act      = act_next;
    st_next.out_a    = route(sel_a, act_next);
    st_next.out_b    = route(sel_b, act_next);
    // consecutive encoder failures; a good exchange breaks the run
    if (cause.enc_comm_ok) begin
      st_next.enc_run = 16'h0000;
    end else if (cause.enc_comm_err && st_reg.enc_run != 16'hFFFF) begin
      st_next.enc_run = st_reg.enc_run + 16'h0001;
    end
    // consecutive data setting warnings escalate; a clear also restarts the run,
    // otherwise a run left above the limit would re-set the error for ever
    if (cause.obj_write && !cause.obj_out_range) begin
      st_next.dset_run = 16'h0000;
    end else if (dset_bad && !link_mask[swm_pkg::slot(7).mbit]
                 && st_reg.dset_run != 16'hFFFF) begin
      st_next.dset_run = st_reg.dset_run + 16'h0001;
    end else if (st_reg.ctrl_clr) begin
      st_next.dset_run = 16'h0000;
    end
    // a new over-limit warning wins over a clear in the same cycle
    if (dset_bad && st_next.dset_run > dset_lim) begin
      st_next.cmd_err = 1'b1;
    end else if (st_reg.ctrl_clr) begin
      st_next.cmd_err = 1'b0;
    end
    // apb: setup, access answered one cycle later, idle
    st_next.ready = 1'b0;
    st_next.err   = 1'b0;
    case (st_reg.bus)
      swm_pkg::ST_IDLE: begin
        if (psel && !penable) begin
          st_next.bus = swm_pkg::ST_SETUP;
        end
      end
      swm_pkg::ST_SETUP: begin
        if (psel && penable) begin
          st_next.bus   = swm_pkg::ST_DONE;
          st_next.ready = 1'b1;
          st_next.err   = (slot_dec == 4'h0);
          st_next.rdata = swm_pkg::SLVERR_NONE;
          if (slot_dec == 4'h1) begin
            st_next.rdata = {20'h00000, st_reg.cmd_err, st_reg.act};
          end else if (slot_dec[3]) begin
            st_next.rdata = {16'h0000, rf_rdata};
          end
          if (pwrite && slot_dec == 4'h2) begin
            st_next.ctrl_rst = pwdata[swm_pkg::CTRL_RESET_BIT[4:0]];
            st_next.ctrl_clr = pwdata[swm_pkg::CTRL_CLRERR_BIT[4:0]];
          end
        end
      end
      swm_pkg::ST_DONE: begin
        st_next.bus = swm_pkg::ST_IDLE;
        if (psel && !penable) begin
          st_next.bus = swm_pkg::ST_SETUP;
        end
      end
      default: st_next.bus = swm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg     <= '0;
      st_reg.bus <= swm_pkg::ST_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata        = st_reg.rdata;
  assign pready        = st_reg.ready;
  assign pslverr       = st_reg.err;
  assign warning_out_a = st_reg.out_a;
  assign warning_out_b = st_reg.out_b;
  assign command_error = st_reg.cmd_err;
endmodule

// >>> logic/swm_pkg.sv
// swm_pkg: constants, register map and carrier types for the warning manager
// assumes an APB slave with 32-bit data; printed offsets are indices, byte addr = 4 * index
// Behaviour
// - overload warning A0 on load >= 85%, mask general bit 7, select code 1
// - regeneration warning A1 on regen load >= 85%, mask bit 5, code 2
// - fan warning A3 only after fan stopped 1 second continuously, mask bit 6, code 4
// - codes A2, A4, A5 unused; never raised, controller must not select them
// - life expectancy warning A7 always latched, mask bit 2, code 8
// - external encoder warning A8 when encoder reports, mask bit 8, code 9
// - encoder comms warning A9 when consecutive errors exceed limit, mask bit 10, code 10
// - selectable warnings latch or not per hold selection setting
// - each output line follows its select value; 0 routes all warnings
// - mask bit 1 suppresses detection; general and link masks separate
// - error reset clears active warnings; persisting cause raises them again
// - data setting warning B0 on out-of-range write, mask link bit 4, code 11
// - command warning B1 on unmet operating conditions, mask link bit 5, code 12
// - command warning on forced brake request while servo energized
// - command warning on switch-on while main power off and object 3508 zero
// - motor travel at 30 mm/s or more is a command warning condition
// - command warning on enable operation while mode of operation unset
// - command warning on latch start in homing, clearing, config or local
// - command warning on motion into prohibited direction after prohibition stop
// - link comms warning B2 after one or more errors, mask link bit 6, code 13
// - non-latch warning clears when cause goes; latch needs error clear
// - hold selection for general warnings is bit 1: 0 non-latch, 1 latch
// - command error when data setting warnings exceed configured consecutive count
package swm_pkg;
  localparam int NW = 11;                       // implemented warning slots
  // register indices, byte address = index * 4
  localparam logic [15:0] IDX_OUT_SEL_A   = 16'h3440;
  localparam logic [15:0] IDX_OUT_SEL_B   = 16'h3441;
  localparam logic [15:0] IDX_GEN_MASK    = 16'h3638;
  localparam logic [15:0] IDX_HOLD_SEL    = 16'h3759;
  localparam logic [15:0] IDX_DSET_LIMIT  = 16'h3781;
  localparam logic [15:0] IDX_LINK_MASK   = 16'h3800;
  localparam logic [15:0] IDX_ENC_LIMIT   = 16'h3F00;
  localparam logic [15:0] IDX_STATUS      = 16'h3F01;
  localparam logic [15:0] IDX_CONTROL     = 16'h3F02;
  localparam logic [15:0] IDX_FAN_TIME    = 16'h3F03;
  localparam logic [31:0] SLVERR_NONE     = 32'h0000_0000;
  localparam logic [15:0] HOLD_GEN_BIT    = 16'h0001;  // bit position of general hold
  localparam logic [15:0] CTRL_RESET_BIT  = 16'h0000;  // error reset bit position
  localparam logic [15:0] CTRL_CLRERR_BIT = 16'h0001;  // clear command error bit position
  localparam logic [6:0]  LOAD_PCT_LIMIT  = 7'h55;     // 85 percent
  localparam logic [15:0] SPEED_LIMIT_MMS = 16'h001E;  // 30 mm/s
  localparam logic [15:0] RESET_16        = 16'h0000;
  localparam logic [15:0] RESET_HOLD      = 16'h0002;  // latch general warnings by default
  localparam logic [15:0] RESET_DSET_LIM  = 16'h0003;
  localparam logic [15:0] RESET_ENC_LIM   = 16'h0003;
  // fan stop time
  localparam int CLK_HZ   = 100_000_000;
  localparam int FAN_MS   = 1000;
  localparam int FAN_CYC  = (CLK_HZ / 1000) * FAN_MS;
  localparam int CNT_W    = 27;

  // per-slot constants: warning code, select code, mask bit, mask group, fixed latch
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] sel;
    logic [3:0] mbit;
    logic       link;      // 1: link mask, 0: general mask
    logic       fixed_latch;
  } swm_slot_s;

  function automatic swm_slot_s slot(input int i);
    case (i)
      0:  slot = '{8'hA0, 4'h1, 4'h7, 1'b0, 1'b0};
      1:  slot = '{8'hA1, 4'h2, 4'h5, 1'b0, 1'b0};
      2:  slot = '{8'hA3, 4'h4, 4'h6, 1'b0, 1'b0};
      3:  slot = '{8'hA6, 4'h7, 4'h9, 1'b0, 1'b0};
      4:  slot = '{8'hA7, 4'h8, 4'h2, 1'b0, 1'b1};
      5:  slot = '{8'hA8, 4'h9, 4'h8, 1'b0, 1'b0};
      6:  slot = '{8'hA9, 4'hA, 4'hA, 1'b0, 1'b0};
      7:  slot = '{8'hB0, 4'hB, 4'h4, 1'b1, 1'b0};
      8:  slot = '{8'hB1, 4'hC, 4'h5, 1'b1, 1'b0};
      9:  slot = '{8'hB2, 4'hD, 4'h6, 1'b1, 1'b0};
      default: slot = '{8'h00, 4'h0, 4'h0, 1'b0, 1'b0};
    endcase
  endfunction

  // drive causes sampled synchronously
  typedef struct packed {
    logic [6:0]  load_pct;
    logic [6:0]  regen_pct;
    logic        fan_stopped;
    logic        vibration;
    logic        life_end;
    logic        enc_warn;
    logic        enc_comm_err;    // one pulse per failed exchange
    logic        enc_comm_ok;     // one pulse per good exchange
    logic        obj_write;       // object write pulse
    logic        obj_out_range;   // range result of that write
    logic        link_comm_err;   // one pulse per link error
  } swm_cause_s;

  // command-warning conditions, each a one-cycle pulse or level
  typedef struct packed {
    logic        cond_unmet;
    logic        brake_req;
    logic        servo_on;
    logic        switch_on_cmd;
    logic        main_power_on;
    logic        obj_3508_zero;
    logic [15:0] speed_mms;
    logic        enable_op_cmd;
    logic        mode_set;
    logic        latch_start;
    logic        homing;
    logic        data_clearing;
    logic        config_busy;
    logic        remote;
    logic        prohib_dir_cmd;
    logic        prohib_stopped;
  } swm_cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SETUP = 3'b010,
    ST_DONE  = 3'b100
  } swm_bus_e;
endpackage

// >>> logic/swm_regfile.sv
// swm_regfile: small storage for the writable settings words
// assumes indices are decoded by the caller; read data come out of a register
`timescale 1ns/10ps
module swm_regfile (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // write port
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [15:0] wdata,
  // read port
  input  wire logic [2:0]  raddr,
  output logic      [15:0] rdata,
  // all words, for the block's logic
  output logic [7:0][15:0] words
);
  typedef struct packed {
    logic [7:0][15:0] mem;
    logic [15:0]      rd;
  } swm_rf_s;
  swm_rf_s st_reg, st_next;

  // write one word, register the read word
  always_comb begin
    st_next = st_reg;
    if (we) begin
      st_next.mem[waddr] = wdata;
    end
    st_next.rd = st_reg.mem[raddr];
  end

  // reset values match the settings' defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= '0;
      st_reg.mem[3] <= swm_pkg::RESET_HOLD;
      st_reg.mem[4] <= swm_pkg::RESET_DSET_LIM;
      st_reg.mem[6] <= swm_pkg::RESET_ENC_LIM;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rd;
  assign words = st_reg.mem;
endmodule

// >>> logic/swm_fan_timer.sv
// swm_fan_timer: flags a fan stop that has lasted the full qualifying time
// assumes the stop level is synchronous to pclk
`timescale 1ns/10ps
module swm_fan_timer #(
  parameter int FAN_CYC = swm_pkg::FAN_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // fan state
  input  wire logic stopped,
  output logic      expired
);
  typedef struct packed {
    logic [swm_pkg::CNT_W-1:0] cnt;
    logic                      exp;
  } swm_fan_s;
  swm_fan_s st_reg, st_next;

  // any run of the fan restarts the wait, so a brief stall never warns
  always_comb begin
    st_next = st_reg;
    if (!stopped) begin
      st_next = '0;
    end else if (st_reg.cnt >= swm_pkg::CNT_W'(FAN_CYC - 1)) begin
      st_next.exp = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.exp;
endmodule

// >>> testbench/swm_top_chk.sv
// swm_top_chk: bus timing and output relations of the warning manager
// assumes ce stays high through every bus transfer
`timescale 1ns/10ps
module swm_top_chk (
  // clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic        warning_out_a,
  input wire logic        warning_out_b,
  input wire logic        command_error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] idx;
  logic        mapped;
  // register decode, kept apart from the design's own decode
  assign idx = paddr[17:2];
  assign mapped = idx inside {swm_pkg::IDX_OUT_SEL_A, swm_pkg::IDX_OUT_SEL_B,
    swm_pkg::IDX_GEN_MASK, swm_pkg::IDX_HOLD_SEL, swm_pkg::IDX_DSET_LIMIT,
    swm_pkg::IDX_LINK_MASK, swm_pkg::IDX_ENC_LIMIT, swm_pkg::IDX_STATUS,
    swm_pkg::IDX_CONTROL};
  // setup then first access cycle
  sequence s_setup;
    psel && !penable && ce ##1 psel && penable && ce;
  endsequence
  sequence s_bad_access;
    psel && penable && !pready && !mapped;
  endsequence
  answer_time_a:
    assert property (s_setup |=> pready) else $error("ready late");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready long");
  ready_cause_a:
    assert property (pready |-> $past(psel && penable)) else $error("ready unasked");
  slverr_unmapped_a:
    assert property (s_bad_access |=> pready && pslverr) else $error("no slverr");
  slverr_mapped_a:
    assert property (pready && pslverr |-> !$past(mapped)) else $error("bad slverr");
  upper_zero_a:
    assert property (pready && !$past(pwrite) |-> prdata[31:16] == 16'h0000)
      else $error("upper bits set");
  reserved_zero_a:
    assert property (pready && !$past(pwrite) && $past(idx) == swm_pkg::IDX_STATUS
      |-> !prdata[10]) else $error("reserved set");
  reset_quiet_a:
    assert property ($rose(presetn) |-> !warning_out_a && !warning_out_b && !command_error)
      else $error("outputs after reset");
  ce_freeze_a:
    assert property (!ce |=> $stable({warning_out_a, warning_out_b, command_error, pready}))
      else $error("moved without ce");
  error_sticky_a:
    assert property (command_error && !(psel && penable && pwrite
      && idx == swm_pkg::IDX_CONTROL) |=> command_error) else $error("error dropped");
endmodule

bind swm_top swm_top_chk swm_top_chk_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .warning_out_a(warning_out_a),
  .warning_out_b(warning_out_b), .command_error(command_error));

// >>> testbench/swm_drive_model.sv
// swm_drive_model: servo and link side, raising the causes the bench selects
// assumes one bit of on per warning slot and csel coding command conditions
`timescale 1ns/10ps
module swm_drive_model (
  // selection from the bench
  input  wire logic          pclk,
  input  wire logic [9:0]    on,
  input  wire logic [2:0]    csel,
  // causes toward the block
  output swm_pkg::swm_cause_s cause,
  output swm_pkg::swm_cmd_s   cmd
);
  initial begin
    cause = '0;
    cmd = '0;
  end
  // idle levels sit one step below each limit, so an off-by-one compare shows
  always @(posedge pclk) begin
    cause <= '0;
    cause.load_pct <= on[0] ? 7'h55 : 7'h54;
    cause.regen_pct <= on[1] ? 7'h55 : 7'h54;
    cause.fan_stopped <= on[2];
    cause.vibration <= on[3];
    cause.life_end <= on[4];
    cause.enc_warn <= on[5];
    cause.enc_comm_err <= on[6];              // every exchange fails
    cause.enc_comm_ok <= !on[6];              // good exchanges break the run
    cause.obj_write <= on[7];
    cause.obj_out_range <= on[7];
    cause.link_comm_err <= on[9];
    cmd <= '0;
    cmd.main_power_on <= csel != 3'h3;
    cmd.mode_set <= csel != 3'h5;
    cmd.remote <= 1'b1;
    cmd.cond_unmet <= on[8];
    cmd.speed_mms <= (csel == 3'h4) ? 16'h001E : 16'h001D;
    case (csel)
      3'h2: {cmd.brake_req, cmd.servo_on} <= 2'b11;
      3'h3: {cmd.switch_on_cmd, cmd.obj_3508_zero} <= 2'b11;
      3'h5: cmd.enable_op_cmd <= 1'b1;
      3'h6: {cmd.latch_start, cmd.homing} <= 2'b11;
      3'h7: {cmd.prohib_dir_cmd, cmd.prohib_stopped} <= 2'b11;
      default: ;
    endcase
  end
endmodule

// >>> testbench/swm_top_bench.sv
// swm_top_bench: register, routing, hold and mask tests of the warning manager
// assumes the drive model supplies causes; short fan time of 20 cycles
`timescale 1ns/10ps
module swm_top_bench;
  logic                pclk, presetn, ce, psel, penable, pwrite, error_reset;
  logic [17:0]         paddr;
  logic [31:0]         pwdata, prdata, rd_data;
  logic                pready, pslverr, rd_err;
  logic                warning_out_a, warning_out_b, command_error;
  swm_pkg::swm_cause_s cause;
  swm_pkg::swm_cmd_s   cmd;
  logic [9:0]          on;
  logic [2:0]          csel;
  logic [3:0]          sel_code [10];
  int                  num_errors, total_checks, cyc;

  swm_top #(.FAN_CYC(20)) swm_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cause(cause), .cmd(cmd),
    .error_reset(error_reset), .warning_out_a(warning_out_a),
    .warning_out_b(warning_out_b), .command_error(command_error));
  swm_drive_model swm_drive_model_inst (.pclk(pclk), .on(on), .csel(csel),
    .cause(cause), .cmd(cmd));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready, never a fixed count
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, well above the seven hundred or so cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    {presetn, ce, psel, penable, pwrite, error_reset} = 6'b010000;
    {paddr, pwdata, on, csel} = '0;
    sel_code = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, swm_pkg::IDX_HOLD_SEL, '0);
    check("hold_rst", rd_data, 32'h2);
    xfer(1'b0, swm_pkg::IDX_GEN_MASK, '0);
    check("gmask_rst", rd_data, 32'h0);
    xfer(1'b0, swm_pkg::IDX_LINK_MASK, '0);
    check("lmask_rst", rd_data, 32'h0);
    xfer(1'b1, swm_pkg::IDX_FAN_TIME, 32'h5);
    check("unmapped", {31'h0, rd_err}, 32'h1);
    xfer(1'b1, swm_pkg::IDX_OUT_SEL_A, 32'hFFFF_000D);
    xfer(1'b0, swm_pkg::IDX_OUT_SEL_A, '0);
    check("sel_a", rd_data, 32'hD);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    // each slot alone: routed to a, not to b, latched, then cleared by control
    for (int i = 0; i < 10; i++) begin
      xfer(1'b1, swm_pkg::IDX_OUT_SEL_A, {28'h0, sel_code[i]});
      xfer(1'b1, swm_pkg::IDX_OUT_SEL_B, {28'h0, sel_code[(i + 1) % 10]});
      on <= 10'h001 << i;
      repeat (30) @(posedge pclk);
      check("line_a", {31'h0, warning_out_a}, 32'h1);
      check("line_b", {31'h0, warning_out_b}, 32'h0);
      on <= '0;
      repeat (3) @(posedge pclk);
      xfer(1'b0, swm_pkg::IDX_STATUS, '0);
      check("status", {22'h0, rd_data[9:0]}, 32'h1 << i);
      check("held", {31'h0, warning_out_a}, 32'h1);
      if (i == 7) begin
        check("cmd_err", {31'h0, command_error}, 32'h1);
        xfer(1'b1, swm_pkg::IDX_CONTROL, 32'h2);
        @(posedge pclk);
        check("cmd_err_clr", {31'h0, command_error}, 32'h0);
      end
      xfer(1'b1, swm_pkg::IDX_CONTROL, 32'h1);
      repeat (2) @(posedge pclk);
      check("cleared", {31'h0, warning_out_a}, 32'h0);
    end
    xfer(1'b1, swm_pkg::IDX_OUT_SEL_A, 32'hC);
    for (int c = 2; c < 8; c++) begin
      csel <= 3'(c);
      repeat (3) @(posedge pclk);
      csel <= '0;
      repeat (3) @(posedge pclk);
      check("cmd_warn", {31'h0, warning_out_a}, 32'h1);
      xfer(1'b1, swm_pkg::IDX_CONTROL, 32'h1);
      repeat (2) @(posedge pclk);
      check("cmd_clr", {31'h0, warning_out_a}, 32'h0);
    end
    xfer(1'b1, swm_pkg::IDX_HOLD_SEL, '0);
    xfer(1'b1, swm_pkg::IDX_OUT_SEL_A, '0);
    xfer(1'b1, swm_pkg::IDX_OUT_SEL_B, 32'h1);
    on <= 10'h001;
    repeat (3) @(posedge pclk);
    check("all_a", {31'h0, warning_out_a}, 32'h1);
    check("only_b", {31'h0, warning_out_b}, 32'h1);
    error_reset <= 1'b1;
    @(posedge pclk);
    error_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    check("persist", {31'h0, warning_out_a}, 32'h1);
    on <= '0;
    repeat (3) @(posedge pclk);
    check("nonlatch", {31'h0, warning_out_a}, 32'h0);
    on <= 10'h004;
    repeat (15) @(posedge pclk);
    on <= '0;
    repeat (2) @(posedge pclk);
    check("fan_short", {31'h0, warning_out_a}, 32'h0);
    on <= 10'h010;
    repeat (3) @(posedge pclk);
    on <= '0;
    repeat (3) @(posedge pclk);
    check("life_latch", {31'h0, warning_out_a}, 32'h1);
    error_reset <= 1'b1;
    @(posedge pclk);
    error_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    check("pin_clear", {31'h0, warning_out_a}, 32'h0);
    xfer(1'b1, swm_pkg::IDX_GEN_MASK, 32'h80);
    xfer(1'b1, swm_pkg::IDX_LINK_MASK, 32'h40);
    on <= 10'h201;
    repeat (3) @(posedge pclk);
    check("masked", {31'h0, warning_out_a}, 32'h0);
    on <= '0;
    finish_test();
  end
endmodule
